// File: bench/dpwm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dpwm_monitor (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        apply,
  input wire logic [1:0]  enable_mode,
  input wire logic        first_phase_level_a,
  input wire logic        first_phase_level_b,
  input wire logic [15:0] delay_us,
  input wire logic        running_a,
  input wire logic        running_b,
  input wire logic        pulse_output_a,
  input wire logic        pulse_output_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // the stop is registered once, so the outputs fall one edge later
  property p_restart;
    apply |-> ##2 (!running_a && !running_b);
  endproperty
  a_restart: assert property (p_restart)
    else $error("outputs still running after apply");
  property p_none;
    apply && enable_mode == 2'h0 ##1 !apply [*3] |-> !running_a && !running_b;
  endproperty
  a_none: assert property (p_none)
    else $error("output running with none enabled");
  property p_start_a;
    apply && enable_mode[0] ##1 !apply [*2] |=>
      running_a && pulse_output_a == $past(first_phase_level_a, 3);
  endproperty
  a_start_a: assert property (p_start_a)
    else $error("output a did not open with first phase");
  property p_only_b;
    apply && enable_mode == 2'h2 ##1 !apply [*2] |=> running_b &&
      !running_a && pulse_output_b == $past(first_phase_level_b, 3);
  endproperty
  a_only_b: assert property (p_only_b)
    else $error("output b alone did not start");
  // in sync mode b must still be stopped three cycles after an apply with any nonzero delay
  property p_lag;
    apply && enable_mode == 2'h3 && delay_us != 16'h0000 ##1 !apply [*3]
      |-> !running_b;
  endproperty
  a_lag: assert property (p_lag)
    else $error("output b started before its delay");
  property p_hold;
    running_a && !apply && !$past(apply) |=> running_a;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output a stopped without apply");
endmodule
bind dpwm_top dpwm_monitor i_mon (.clk_sys, .nrst, .apply, .enable_mode,
  .first_phase_level_a, .first_phase_level_b, .delay_us, .running_a,
  .running_b, .pulse_output_a, .pulse_output_b);
`default_nettype wire

// File: bench/dpwm_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module dpwm_top_test;
  logic        clk_sys = 0;
  logic        nrst = 0;
  logic        apply = 0;
  logic [1:0]  mode = 0;
  logic        lv_a = 1;
  logic        lv_b = 1;
  logic [12:0] per_a = 1;
  logic [12:0] per_b = 1;
  logic [6:0]  pc_a = 1;
  logic [6:0]  pc_b = 1;
  logic [15:0] dly = 0;
  wire         out_a, out_b, run_a, run_b, clamped;
  int          err_total = 0;
  int          cmp_count = 0;
  dpwm_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .apply(apply),
    .enable_mode(mode), .first_phase_level_a(lv_a),
    .first_phase_level_b(lv_b), .period_us_a(per_a), .period_us_b(per_b),
    .first_phase_percent_a(pc_a), .first_phase_percent_b(pc_b),
    .delay_us(dly), .pulse_output_a(out_a), .pulse_output_b(out_b),
    .running_a(run_a), .running_b(run_b), .setting_clamped(clamped));
  initial forever #50 clk_sys = ~clk_sys;
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  // one step after the strobe so the previous run is already stopped
  task automatic go(input logic [1:0] m, input logic la, input logic lb,
    input logic [12:0] pa, input logic [12:0] pb, input logic [6:0] ca,
    input logic [6:0] cb, input logic [15:0] d);
    {mode, lv_a, lv_b, per_a, per_b, pc_a, pc_b, dly} =
      {m, la, lb, pa, pb, ca, cb, d};
    apply = 1;
    step;
    apply = 0;
    step;
  endtask
  task automatic meas(input logic b, output int h, output int l);
    logic lv;
    lv = b ? lv_b : lv_a;
    for (h = 0; (b ? run_b : run_a) !== 1'b1 && h < 999; h++) step;
    for (h = 0; (b ? out_b : out_a) === lv && h < 9999; h++) step;
    for (l = 0; (b ? out_b : out_a) === !lv && l < 9999; l++) step;
  endtask
  task automatic t_walk;
    int h, l;
    go(2'h1, 1'b1, 1'b1, 13'h0002, 13'h0002, 7'h32, 7'h32, 16'h0000);
    meas(1'b0, h, l);
    chk(h, 10);
    chk(l, 10);
    chk(run_b, 0);
    chk(out_b, 0);
    $display("t_walk done");
  endtask
  task automatic t_round;
    int h, l;
    go(2'h2, 1'b0, 1'b0, 13'h0001, 13'h0003, 7'h32, 7'h2c, 16'h0000);
    meas(1'b1, h, l);
    chk(h, 13);
    chk(l, 17);
    chk(run_a, 0);
    $display("t_round done");
  endtask
  task automatic t_edges;
    int h, l;
    logic [6:0] pc [3] = '{7'h01, 7'h63, 7'h32};
    logic [12:0] pr [3] = '{13'h0001, 13'h0001, 13'h0000};
    int hx [3] = '{1, 9, 5};
    int lx [3] = '{9, 1, 5};
    for (int i = 0; i < 3; i++) begin
      go(2'h1, 1'b0, 1'b1, pr[i], 13'h0001, pc[i], 7'h32, 16'h0000);
      meas(1'b0, h, l);
      chk(h, hx[i]);
      chk(l, lx[i]);
      chk(clamped, i == 2);
    end
    $display("t_edges done");
  endtask
  task automatic t_sync;
    int n, h, l;
    go(2'h3, 1'b1, 1'b0, 13'h0002, 13'h0003, 7'h32, 7'h38, 16'h0005);
    for (n = 0; run_a !== 1'b1 && n < 99; n++) step;
    for (n = 0; run_b !== 1'b1 && n < 999; n++) step;
    chk(n, 50);
    chk(out_a, 0);
    meas(1'b1, h, l);
    chk(h, 17);
    chk(l, 13);
    go(2'h0, 1'b1, 1'b1, 13'h0002, 13'h0002, 7'h32, 7'h32, 16'h0000);
    repeat (5) step;
    chk({run_a, run_b}, 0);
    $display("t_sync done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 nrst = 1;
    repeat (4) step;
    t_walk;
    t_round;
    t_edges;
    t_sync;
    tally_and_finish;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: rtl/dpwm_map.vh
`ifndef DPWM_MAP_VH
`define DPWM_MAP_VH

// clock and time base
`define DPWM_CLK_PERIOD_NS   100
`define DPWM_US_NS           1000
`define DPWM_CYC_PER_US      (`DPWM_US_NS / `DPWM_CLK_PERIOD_NS)

// period limits in microseconds: 1 MHz and 160 Hz
`define DPWM_PERIOD_MIN_US   13'h0001
`define DPWM_PERIOD_MAX_US   13'h186a

// first phase percentage limits
`define DPWM_PCT_MIN         7'h01
`define DPWM_PCT_MAX         7'h63
`define DPWM_PCT_FULL        7'h64

// enable setting codes
`define DPWM_EN_NONE         2'h0
`define DPWM_EN_A            2'h1
`define DPWM_EN_B            2'h2
`define DPWM_EN_SYNC         2'h3

// reset values
`define DPWM_RST_LEVEL       1'b1
`define DPWM_RST_MODE        2'h0

`endif

// File: rtl/dpwm_top.v
// Summary of operation
// - Enable setting both runs the two outputs synchronised, none disables both.
// - Each output drives its first phase at the chosen level and the second at the opposite.
// - Each output has its own period in microseconds, from 160 Hz up to 1 MHz.
// - The first phase lasts the given integer percentage, 1 to 99, of the period.
// - When synchronised, output b's first phase starts the given delay after a's.
`timescale 1ns/1ns
`default_nettype none
`include "dpwm_map.vh"

module dpwm_chan #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          restart,
  input  wire          stop,
  input  wire          level,
  input  wire [CW-1:0] period_cnt,
  input  wire [CW-1:0] high_cnt,
  output reg           pulse,
  output reg           active
);
  reg  [CW-1:0] cnt;
  wire [CW-1:0] cnt_inc;

  assign cnt_inc = cnt + {{(CW-1){1'b0}}, 1'b1};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= {CW{1'b0}};
      pulse  <= 1'b0;
      active <= 1'b0;
    end else if (stop) begin
      // idle output rests at the second phase level
      cnt    <= {CW{1'b0}};
      pulse  <= ~level;
      active <= 1'b0;
    end else if (restart) begin
      cnt    <= {CW{1'b0}};
      pulse  <= level;
      active <= 1'b1;
    end else if (active) begin
      if (cnt == period_cnt - {{(CW-1){1'b0}}, 1'b1}) begin
        cnt   <= {CW{1'b0}};
        pulse <= level;
      end else begin
        cnt <= cnt_inc;
        pulse <= (cnt_inc < high_cnt) ? level : ~level;
      end
    end else begin
      pulse <= ~level;
    end
  end
endmodule

module dpwm_top #(
  parameter CW = 16,
  parameter DW = 24
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        apply,
  input  wire [1:0]  enable_mode,
  input  wire        first_phase_level_a,
  input  wire        first_phase_level_b,
  input  wire [12:0] period_us_a,
  input  wire [12:0] period_us_b,
  input  wire [6:0]  first_phase_percent_a,
  input  wire [6:0]  first_phase_percent_b,
  input  wire [15:0] delay_us,
  output wire        pulse_output_a,
  output wire        pulse_output_b,
  output wire        running_a,
  output wire        running_b,
  output reg         setting_clamped
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_WAIT  = 2'h2;

  localparam [CW-1:0] CYC_US = `DPWM_CYC_PER_US;
  localparam [DW-1:0] CYC_US_D = `DPWM_CYC_PER_US;

  reg           rst_meta;
  reg           rst_n;
  reg  [1:0]    state;
  reg  [1:0]    mode;
  reg           lvl_a;
  reg           lvl_b;
  reg  [CW-1:0] per_a;
  reg  [CW-1:0] per_b;
  reg  [CW-1:0] hi_a;
  reg  [CW-1:0] hi_b;
  reg  [DW-1:0] dly;
  reg  [DW-1:0] timer;
  reg           stop_all;
  reg           go_a;
  reg           go_b;

  wire [12:0]   us_a;
  wire [12:0]   us_b;
  wire [6:0]    pct_a;
  wire [6:0]    pct_b;
  wire [CW-1:0] cyc_a;
  wire [CW-1:0] cyc_b;
  wire [CW-1:0] high_a;
  wire [CW-1:0] high_b;
  wire          clamped;

  // reset release through two flops
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // hold the period inside 160 Hz .. 1 MHz
  assign us_a = (period_us_a < `DPWM_PERIOD_MIN_US) ? `DPWM_PERIOD_MIN_US :
                (period_us_a > `DPWM_PERIOD_MAX_US) ? `DPWM_PERIOD_MAX_US :
                period_us_a;
  assign us_b = (period_us_b < `DPWM_PERIOD_MIN_US) ? `DPWM_PERIOD_MIN_US :
                (period_us_b > `DPWM_PERIOD_MAX_US) ? `DPWM_PERIOD_MAX_US :
                period_us_b;

  // only 1 to 99 percent accepted
  assign pct_a = (first_phase_percent_a < `DPWM_PCT_MIN) ? `DPWM_PCT_MIN :
                 (first_phase_percent_a > `DPWM_PCT_MAX) ? `DPWM_PCT_MAX :
                 first_phase_percent_a;
  assign pct_b = (first_phase_percent_b < `DPWM_PCT_MIN) ? `DPWM_PCT_MIN :
                 (first_phase_percent_b > `DPWM_PCT_MAX) ? `DPWM_PCT_MAX :
                 first_phase_percent_b;

  assign clamped = (us_a != period_us_a) || (us_b != period_us_b) ||
                   (pct_a != first_phase_percent_a) ||
                   (pct_b != first_phase_percent_b);

  assign cyc_a = {{(CW-13){1'b0}}, us_a} * CYC_US;
  assign cyc_b = {{(CW-13){1'b0}}, us_b} * CYC_US;

  function [CW-1:0] high_count;
    input [CW-1:0] cyc;
    input [6:0]    pct;
    reg   [CW+7:0] prod;
    reg   [CW+7:0] q;
    begin
      // half of the full scale, kept at the product width
      prod = cyc * pct + ({{(CW+1){1'b0}}, `DPWM_PCT_FULL} >> 1);
      q    = prod / `DPWM_PCT_FULL;
      // keep both phases at least one cycle long at the fastest rate
      if (q == {(CW+8){1'b0}})
        high_count = {{(CW-1){1'b0}}, 1'b1};
      else if (q[CW-1:0] >= cyc)
        high_count = cyc - {{(CW-1){1'b0}}, 1'b1};
      else
        high_count = q[CW-1:0];
    end
  endfunction

  assign high_a = high_count(cyc_a, pct_a);
  assign high_b = high_count(cyc_b, pct_b);

  // settings are latched on apply so a running period never sees a
  // half-written value
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode            <= `DPWM_RST_MODE;
      lvl_a           <= `DPWM_RST_LEVEL;
      lvl_b           <= `DPWM_RST_LEVEL;
      per_a           <= {CW{1'b0}};
      per_b           <= {CW{1'b0}};
      hi_a            <= {CW{1'b0}};
      hi_b            <= {CW{1'b0}};
      dly             <= {DW{1'b0}};
      setting_clamped <= 1'b0;
    end else if (apply) begin
      mode            <= enable_mode;
      lvl_a           <= first_phase_level_a;
      lvl_b           <= first_phase_level_b;
      per_a           <= cyc_a;
      per_b           <= cyc_b;
      hi_a            <= high_a;
      hi_b            <= high_b;
      dly             <= {{(DW-16){1'b0}}, delay_us} * CYC_US_D;
      setting_clamped <= clamped;
    end
  end

  // start sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      timer    <= {DW{1'b0}};
      stop_all <= 1'b0;
      go_a     <= 1'b0;
      go_b     <= 1'b0;
    end else begin
      stop_all <= 1'b0;
      go_a     <= 1'b0;
      go_b     <= 1'b0;
      if (apply) begin
        // any new setting stops both outputs and starts over
        stop_all <= 1'b1;
        state    <= ST_START;
      end else begin
        case (state)
          ST_IDLE: begin
            timer <= {DW{1'b0}};
          end
          ST_START: begin
            go_a  <= mode[0];
            go_b  <= (mode == `DPWM_EN_B) ||
                     ((mode == `DPWM_EN_SYNC) && (dly == {DW{1'b0}}));
            timer <= {{(DW-1){1'b0}}, 1'b1};
            if ((mode == `DPWM_EN_SYNC) && (dly != {DW{1'b0}}))
              state <= ST_WAIT;
            else
              state <= ST_IDLE;
          end
          ST_WAIT: begin
            // b lags a by the delay
            if (timer == dly) begin
              go_b  <= 1'b1;
              state <= ST_IDLE;
            end else begin
              timer <= timer + {{(DW-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // both channels share one start reference
  dpwm_chan #(
    .CW (CW)
  ) u_chan_a (
    .clk        (clk_sys),
    .rst_n      (rst_n),
    .restart    (go_a),
    .stop       (stop_all),
    .level      (lvl_a),
    .period_cnt (per_a),
    .high_cnt   (hi_a),
    .pulse      (pulse_output_a),
    .active     (running_a)
  );

  dpwm_chan #(
    .CW (CW)
  ) u_chan_b (
    .clk        (clk_sys),
    .rst_n      (rst_n),
    .restart    (go_b),
    .stop       (stop_all),
    .level      (lvl_b),
    .period_cnt (per_b),
    .high_cnt   (hi_b),
    .pulse      (pulse_output_b),
    .active     (running_b)
  );
endmodule

`default_nettype wire
